// file: fcs_map.svh
// constants for the flash command sequencer
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// ----------------------------------------
// addresses, patterns, sizes, bit positions and cycle counts
// ----------------------------------------
`define FCS_CTRL_ADDR 16'h0FFF
`define FCS_FREQ_ADDR 16'h0FFE
`define FCS_UNLOCK1 16'h4555
`define FCS_UNLOCK2 16'h4AAA
`define FCS_DAT_AA 8'hAA
`define FCS_DAT_55 8'h55
`define FCS_DAT_80 8'h80
`define FCS_DAT_SE 8'h30
`define FCS_DAT_PG 8'hA0
`define FCS_EN_PAT 4'h3
`define FCS_DIS_PAT 8'hC8
`define FCS_CTRL_RST 8'hC8
`define FCS_BOOT_LO 16'h3000
`define FCS_BOOT_HI 16'h3FFF
`define FCS_BOOT_SIZE 4096
`define FCS_FLASH_LO 16'hC000
`define FCS_TOGGLE_BIT 6
`define FCS_SECTOR_MSB 15
`define FCS_SECTOR_LSB 12
`define FCS_PROG_CYC 16'h0040
`define FCS_ERASE_CYC 16'h1000
`define FCS_GARBAGE 8'hFF
`endif

// file: fcs_pkg.sv
// types for the flash command sequencer
package fcs_pkg;
   typedef enum logic [2:0] {
      FCS_IDLE, FCS_U1, FCS_U2, FCS_U3, FCS_U4, FCS_U5, FCS_BUSY
   } fcs_state_e;
   typedef enum logic [1:0] {FCS_OP_NONE, FCS_OP_PROG, FCS_OP_ERASE} fcs_op_e;
   typedef struct packed {
      fcs_state_e st;
      fcs_op_e op;
      logic [7:0] ctrl;
      logic [15:0] cnt;
      logic toggle;
      logic [7:0] rdata;
      logic [15:0] fl_addr;
      logic [7:0] fl_wdata;
      logic fl_prog;
      logic fl_erase;
      logic busy;
      logic prom;
      logic strap_done;
   } fcs_state_s;
endpackage

// file: fcs_sequencer.sv
// flash command sequencer with unlock decode, busy toggle and memory map
`timescale 1ns/1ps
`include "fcs_map.svh"
module fcs_sequencer (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic prom_strap,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] flash_rdata,
   input wire logic [7:0] boot_rdata,
   input wire logic [7:0] freq_rdata,
   output logic [7:0] rdata,
   output logic [15:0] flash_addr,
   output logic [7:0] flash_wdata,
   output logic flash_prog,
   output logic flash_erase,
   output logic busy,
   output logic prom_mode
);
   fcs_pkg::fcs_state_s s_reg, s_next;
   logic unlocked;
   logic in_flash, in_boot, in_freq, is_ctrl;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   assign unlocked = (s_reg.ctrl[7:4] == `FCS_EN_PAT);
   assign in_flash = (addr >= `FCS_FLASH_LO);
   assign in_boot = s_reg.prom && (addr >= `FCS_BOOT_LO) && (addr <= `FCS_BOOT_HI);
   assign in_freq = !s_reg.prom && (addr == `FCS_FREQ_ADDR);
   assign is_ctrl = (addr == `FCS_CTRL_ADDR);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.fl_prog = 1'b0;
      s_next.fl_erase = 1'b0;
      if (!s_reg.strap_done) begin
         s_next.prom = prom_strap;
         s_next.strap_done = 1'b1;
      end
      if (wr && is_ctrl) begin
         s_next.ctrl = wdata;
      end
      // read path
      if (rd) begin
         if (is_ctrl) begin
            s_next.rdata = s_reg.ctrl;
         end else if (in_boot) begin
            s_next.rdata = boot_rdata;
         end else if (in_freq) begin
            s_next.rdata = freq_rdata;
         end else if (in_flash && s_reg.busy) begin
            s_next.rdata = `FCS_GARBAGE;
            s_next.rdata[`FCS_TOGGLE_BIT] = s_reg.toggle;
            s_next.toggle = !s_reg.toggle;
         end else if (in_flash) begin
            s_next.rdata = flash_rdata;
         end else begin
            s_next.rdata = 8'h00;
         end
      end
      // unlock sequence
      if (wr && !is_ctrl && s_reg.st != fcs_pkg::FCS_BUSY) begin
         s_next.st = fcs_pkg::FCS_IDLE;
         if (unlocked) begin
            case (s_reg.st)
               fcs_pkg::FCS_IDLE: begin
                  if (addr == `FCS_UNLOCK1 && wdata == `FCS_DAT_AA) begin
                     s_next.st = fcs_pkg::FCS_U1;
                  end
               end
               fcs_pkg::FCS_U1: begin
                  if (addr == `FCS_UNLOCK2 && wdata == `FCS_DAT_55) begin
                     s_next.st = fcs_pkg::FCS_U2;
                  end
               end
               fcs_pkg::FCS_U2: begin
                  if (addr == `FCS_UNLOCK1 && wdata == `FCS_DAT_80) begin
                     s_next.st = fcs_pkg::FCS_U3;
                  end else if (addr == `FCS_UNLOCK1 && wdata == `FCS_DAT_PG) begin
                     s_next.st = fcs_pkg::FCS_U5;
                     s_next.op = fcs_pkg::FCS_OP_PROG;
                  end
               end
               fcs_pkg::FCS_U3: begin
                  if (addr == `FCS_UNLOCK1 && wdata == `FCS_DAT_AA) begin
                     s_next.st = fcs_pkg::FCS_U4;
                  end
               end
               fcs_pkg::FCS_U4: begin
                  if (addr == `FCS_UNLOCK2 && wdata == `FCS_DAT_55) begin
                     s_next.st = fcs_pkg::FCS_U5;
                     s_next.op = fcs_pkg::FCS_OP_ERASE;
                  end
               end
               fcs_pkg::FCS_U5: begin
                  if (in_flash && s_reg.op == fcs_pkg::FCS_OP_PROG) begin
                     s_next.st = fcs_pkg::FCS_BUSY;
                     s_next.fl_prog = 1'b1;
                     s_next.fl_addr = addr;
                     s_next.fl_wdata = wdata;
                     s_next.cnt = `FCS_PROG_CYC;
                  end else if (in_flash && wdata == `FCS_DAT_SE) begin
                     s_next.st = fcs_pkg::FCS_BUSY;
                     s_next.fl_erase = 1'b1;
                     s_next.fl_addr = {addr[`FCS_SECTOR_MSB:`FCS_SECTOR_LSB], 12'h000};
                     s_next.fl_wdata = wdata;
                     s_next.cnt = `FCS_ERASE_CYC;
                  end
               end
               default: s_next.st = fcs_pkg::FCS_IDLE;
            endcase
         end
      end
      if (s_next.st == fcs_pkg::FCS_BUSY && s_reg.st != fcs_pkg::FCS_BUSY) begin
         s_next.busy = 1'b1;
         s_next.toggle = 1'b1;
      end
      if (s_reg.st == fcs_pkg::FCS_BUSY) begin
         if (s_reg.cnt <= 16'h0001) begin
            s_next.st = fcs_pkg::FCS_IDLE;
            s_next.busy = 1'b0;
            s_next.op = fcs_pkg::FCS_OP_NONE;
            s_next.cnt = 16'h0000;
         end else begin
            s_next.cnt = s_reg.cnt - 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.ctrl <= `FCS_CTRL_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata = s_reg.rdata;
   assign flash_addr = s_reg.fl_addr;
   assign flash_wdata = s_reg.fl_wdata;
   assign flash_prog = s_reg.fl_prog;
   assign flash_erase = s_reg.fl_erase;
   assign busy = s_reg.busy;
   assign prom_mode = s_reg.prom;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence prog_tail_q;
      wr && addr >= `FCS_FLASH_LO && s_reg.st == fcs_pkg::FCS_U5
         && s_reg.op == fcs_pkg::FCS_OP_PROG && unlocked;
   endsequence

   locked_no_cmd_a: assert property (@(posedge mclk) disable iff (!rstn)
      !unlocked && s_reg.st == fcs_pkg::FCS_IDLE |=> s_reg.st == fcs_pkg::FCS_IDLE)
      else $error("sequence advanced while locked");

   disable_blocks_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && is_ctrl && wdata == `FCS_DIS_PAT |=> !unlocked)
      else $error("disable pattern left commands enabled");

   prog_start_a: assert property (@(posedge mclk) disable iff (!rstn)
      prog_tail_q |=> flash_prog && busy && flash_addr == $past(addr))
      else $error("byte program not started");

   erase_start_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U5 && s_reg.op == fcs_pkg::FCS_OP_ERASE
      && in_flash && wdata == `FCS_DAT_SE |=> flash_erase ##1 !flash_erase && busy)
      else $error("sector erase not started");

   toggle_first_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(busy) && rd && in_flash |=> rdata[`FCS_TOGGLE_BIT])
      else $error("first busy read bit six not one");

   toggle_flip_a: assert property (@(posedge mclk) disable iff (!rstn)
      busy && rd && in_flash ##1 busy && rd && in_flash
      |=> rdata[`FCS_TOGGLE_BIT] != $past(rdata[`FCS_TOGGLE_BIT]))
      else $error("bit six failed to toggle");

   busy_no_array_a: assert property (@(posedge mclk) disable iff (!rstn)
      busy && rd && in_flash |=> (rdata | 8'h40) == (`FCS_GARBAGE | 8'h40))
      else $error("array data served while busy");

   break_abandon_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && !is_ctrl && s_reg.st == fcs_pkg::FCS_U1 && addr != `FCS_UNLOCK2
      |=> s_reg.st == fcs_pkg::FCS_IDLE && !flash_prog && !flash_erase)
      else $error("broken unlock not abandoned");

   boot_window_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && !prom_mode && addr >= `FCS_BOOT_LO && addr <= `FCS_BOOT_HI
      |=> rdata == 8'h00)
      else $error("boot rom visible outside prom mode");

   // ----------------------------------------
   // unlock steps
   // ----------------------------------------
   sequence unlock_first_q;
      wr && unlocked && s_reg.st == fcs_pkg::FCS_IDLE
         && addr == `FCS_UNLOCK1 && wdata == `FCS_DAT_AA;
   endsequence

   sequence unlock_second_q;
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U1
         && addr == `FCS_UNLOCK2 && wdata == `FCS_DAT_55;
   endsequence

   step_one_a: assert property (@(posedge mclk) disable iff (!rstn)
      unlock_first_q |=> s_reg.st == fcs_pkg::FCS_U1)
      else $error("first unlock write not taken");

   step_two_a: assert property (@(posedge mclk) disable iff (!rstn)
      unlock_second_q |=> s_reg.st == fcs_pkg::FCS_U2)
      else $error("second unlock write not taken");

   erase_cmd_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U2 && addr == `FCS_UNLOCK1
      && wdata == `FCS_DAT_80 |=> s_reg.st == fcs_pkg::FCS_U3)
      else $error("erase command write not taken");

   prog_cmd_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U2 && addr == `FCS_UNLOCK1
      && wdata == `FCS_DAT_PG |=> s_reg.st == fcs_pkg::FCS_U5
      && s_reg.op == fcs_pkg::FCS_OP_PROG)
      else $error("program command write not taken");

   erase_fourth_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U3 && addr == `FCS_UNLOCK1
      && wdata == `FCS_DAT_AA |=> s_reg.st == fcs_pkg::FCS_U4)
      else $error("fourth erase write not taken");

   erase_fifth_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && unlocked && s_reg.st == fcs_pkg::FCS_U4 && addr == `FCS_UNLOCK2
      && wdata == `FCS_DAT_55 |=> s_reg.st == fcs_pkg::FCS_U5
      && s_reg.op == fcs_pkg::FCS_OP_ERASE)
      else $error("fifth erase write not taken");

   locked_no_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
      !unlocked && !busy |=> !flash_prog && !flash_erase)
      else $error("array operation started while locked");

   enable_opens_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && is_ctrl && wdata[7:4] == `FCS_EN_PAT |=> unlocked)
      else $error("enable pattern did not open commands");

   ctrl_write_a: assert property (@(posedge mclk) disable iff (!rstn)
      wr && is_ctrl |=> s_reg.ctrl == $past(wdata))
      else $error("control register write lost");

   ctrl_read_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && is_ctrl |=> rdata == $past(s_reg.ctrl))
      else $error("control register read wrong");

   // ----------------------------------------
   // array pulses
   // ----------------------------------------
   prog_one_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_prog |=> !flash_prog)
      else $error("program pulse longer than one cycle");

   erase_one_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_erase |=> !flash_erase)
      else $error("erase pulse longer than one cycle");

   pulse_excl_a: assert property (@(posedge mclk) disable iff (!rstn)
      !(flash_prog && flash_erase))
      else $error("program and erase at once");

   prog_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_prog |-> busy && s_reg.cnt == `FCS_PROG_CYC)
      else $error("program pulse without busy count");

   erase_busy_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_erase |-> busy && s_reg.cnt == `FCS_ERASE_CYC)
      else $error("erase pulse without busy count");

   erase_align_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_erase |-> flash_addr[11:0] == 12'h000 && flash_addr >= `FCS_FLASH_LO)
      else $error("erase address not a flash sector");

   prog_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
      flash_prog |-> flash_addr >= `FCS_FLASH_LO)
      else $error("program address outside flash");

   prog_data_a: assert property (@(posedge mclk) disable iff (!rstn)
      prog_tail_q |=> flash_wdata == $past(wdata))
      else $error("program data not carried");

   // ----------------------------------------
   // busy window
   // ----------------------------------------
   busy_ignore_a: assert property (@(posedge mclk) disable iff (!rstn)
      busy && wr && !is_ctrl |=> !flash_prog && !flash_erase)
      else $error("new operation started while busy");

   busy_stays_a: assert property (@(posedge mclk) disable iff (!rstn)
      busy && s_reg.cnt > 16'h0001 |=> busy)
      else $error("busy dropped early");

   busy_ends_a: assert property (@(posedge mclk) disable iff (!rstn)
      busy && s_reg.cnt == 16'h0001 |=> !busy)
      else $error("busy held too long");

   toggle_start_a: assert property (@(posedge mclk) disable iff (!rstn)
      $rose(busy) |-> s_reg.toggle)
      else $error("toggle not set at start");

   idle_array_a: assert property (@(posedge mclk) disable iff (!rstn)
      !busy && rd && in_flash |=> rdata == $past(flash_rdata))
      else $error("array read wrong while idle");

   rdata_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
      !rd |=> rdata == $past(rdata))
      else $error("read data changed without a read");

   // ----------------------------------------
   // memory map
   // ----------------------------------------
   boot_read_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && in_boot |=> rdata == $past(boot_rdata))
      else $error("boot rom read wrong");

   freq_read_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && !prom_mode && addr == `FCS_FREQ_ADDR |=> rdata == $past(freq_rdata))
      else $error("frequency register read wrong");

   freq_block_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && prom_mode && addr == `FCS_FREQ_ADDR |=> rdata == 8'h00)
      else $error("frequency register visible in prom mode");

   unmapped_a: assert property (@(posedge mclk) disable iff (!rstn)
      rd && !in_flash && !is_ctrl && !in_boot && !in_freq |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   mode_fixed_a: assert property (@(posedge mclk) disable iff (!rstn)
      s_reg.strap_done |=> prom_mode == $past(prom_mode))
      else $error("operating mode changed after reset");
endmodule

// file: fcs_flash_model.sv
// flash array model beside the sequencer
`timescale 1ns/1ps
module fcs_flash_model (
   input wire logic mclk,
   input wire logic [15:0] addr,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_wdata,
   input wire logic flash_prog,
   input wire logic flash_erase,
   output logic [7:0] flash_rdata,
   output logic [7:0] boot_rdata,
   output logic [7:0] freq_rdata
);
   // ----------------------------------------
   // array storage, erased at start
   // ----------------------------------------
   logic [7:0] mem [0:65535];
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
   end
   assign flash_rdata = mem[addr];
   assign boot_rdata = addr[7:0] ^ 8'hA5;
   assign freq_rdata = 8'h3C;
   // program clears bits, erase sets the whole sector
   always @(posedge mclk) begin
      if (flash_prog) mem[flash_addr] <= mem[flash_addr] & flash_wdata;
      if (flash_erase) begin
         for (int i = 0; i < 4096; i++) mem[{flash_addr[15:12], 12'h000} + i] <= 8'hFF;
      end
   end
endmodule

// file: tb_top.sv
// testbench for the flash command sequencer
`timescale 1ns/1ps
`include "fcs_map.svh"
module tb_top;
   // ----------------------------------------
   // signals, clock, instances
   // ----------------------------------------
   logic mclk = 1'b0, rstn = 1'b0, prom_strap = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000, flash_addr;
   logic [7:0] wdata = 8'h00, rdata, flash_rdata, boot_rdata, freq_rdata, flash_wdata;
   logic flash_prog, flash_erase, busy, prom_mode;
   int n_mismatch = 0, samples_checked = 0;
   always #4 mclk = ~mclk;
   fcs_sequencer uut (.mclk(mclk), .rstn(rstn), .prom_strap(prom_strap), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .flash_rdata(flash_rdata), .boot_rdata(boot_rdata),
      .freq_rdata(freq_rdata), .rdata(rdata), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_prog(flash_prog), .flash_erase(flash_erase),
      .busy(busy), .prom_mode(prom_mode));
   fcs_flash_model fm (.mclk(mclk), .addr(addr), .flash_addr(flash_addr),
      .flash_wdata(flash_wdata), .flash_prog(flash_prog), .flash_erase(flash_erase),
      .flash_rdata(flash_rdata), .boot_rdata(boot_rdata), .freq_rdata(freq_rdata));
   // ----------------------------------------
   // bus tasks and checks
   // ----------------------------------------
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task do_reset(input logic strap);
      rstn <= 1'b0;
      prom_strap <= strap;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask
   task wr_b(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk("rdata", rdata, exp);
   endtask
   task unlock(input logic [7:0] cmd);
      wr_b(`FCS_UNLOCK1, `FCS_DAT_AA);
      wr_b(`FCS_UNLOCK2, `FCS_DAT_55);
      wr_b(`FCS_UNLOCK1, cmd);
   endtask
   task wait_idle;
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge mclk);
      chk("busy", busy, 1'b0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      do_reset(1'b0);
      chk("prom_mode", prom_mode, 1'b0);
      unlock(`FCS_DAT_PG);
      wr_b(16'hE000, 8'h3F);
      @(negedge mclk);
      chk("busy", busy, 1'b0);
      rd_chk(`FCS_FREQ_ADDR, 8'h3C);
      rd_chk(16'h3012, 8'h00);
      wr_b(`FCS_CTRL_ADDR, 8'h38);
      unlock(`FCS_DAT_PG);
      wr_b(16'hE000, 8'h3F);
      @(negedge mclk);
      chk("busy", busy, 1'b1);
      chk("flash_prog", flash_prog, 1'b1);
      chk("flash_addr", flash_addr, 16'hE000);
      chk("flash_wdata", flash_wdata, 8'h3F);
      rd_chk(16'hE000, 8'hFF);
      rd_chk(16'hE000, 8'hBF);
      rd_chk(16'hE000, 8'hFF);
      wait_idle();
      rd_chk(16'hE000, 8'h3F);
      wr_b(`FCS_UNLOCK1, `FCS_DAT_AA);
      wr_b(`FCS_UNLOCK2, `FCS_DAT_55);
      wr_b(`FCS_UNLOCK1, `FCS_DAT_80);
      unlock(`FCS_DAT_AA);
      wr_b(16'hE123, `FCS_DAT_SE);
      @(negedge mclk);
      chk("busy", busy, 1'b0);
      rd_chk(16'hE000, 8'h3F);
      unlock(`FCS_DAT_80);
      wr_b(`FCS_UNLOCK1, `FCS_DAT_AA);
      wr_b(`FCS_UNLOCK2, `FCS_DAT_55);
      wr_b(16'hE123, `FCS_DAT_SE);
      @(negedge mclk);
      chk("busy", busy, 1'b1);
      chk("flash_erase", flash_erase, 1'b1);
      chk("flash_addr", flash_addr, 16'hE000);
      wait_idle();
      rd_chk(16'hE000, 8'hFF);
      wr_b(`FCS_CTRL_ADDR, `FCS_DIS_PAT);
      unlock(`FCS_DAT_PG);
      wr_b(16'hE000, 8'h00);
      @(negedge mclk);
      chk("busy", busy, 1'b0);
      do_reset(1'b1);
      chk("prom_mode", prom_mode, 1'b1);
      rd_chk(16'h3012, 8'hB7);
      rd_chk(`FCS_BOOT_HI, 8'h5A);
      rd_chk(`FCS_FREQ_ADDR, 8'h00);
      close_out();
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      close_out();
   end
endmodule
